// >>> logic/fpe_defines.svh
// Summary of operation
// - No hardware standby while high supply present.
// - Other peripherals unchanged in user mode.
// - Array reads invalid during program or erase.
// - Mode bits select program, erase, verify modes.
// - Flash write latches address and data; writes during a program or erase pulse are dropped.
// - Program stress only while program bit set.
// - Program verify reads latched address with bias.
// - Program targets above 32 KB are invalid.
// - Erase only while erase bit set.
// - Erase verify dummy write all ones applies bias.
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

// ************************************************
// Register indices, byte address is index times four
// ************************************************
`define FPE_IDX_W 16
`define FPE_IDX_MODE 16'hff80
`define FPE_IDX_EBS1 16'hff82
`define FPE_IDX_EBS2 16'hff83
`define FPE_IDX_STAT 16'hff84
`define FPE_IDX_LADR 16'hff85
`define FPE_IDX_LDAT 16'hff86

// ************************************************
// Field positions and reset values
// ************************************************
`define FPE_BIT_PROG 0
`define FPE_BIT_ERASE 1
`define FPE_BIT_PV 2
`define FPE_BIT_EV 3
`define FPE_BIT_VPP 7
`define FPE_MODE_WMASK 8'h0f
`define FPE_ALL_WMASK 8'hff
`define FPE_RST_BYTE 8'h00
`define FPE_ST_ADR_ERR 0
`define FPE_ST_UPM 1
`define FPE_ST_BUSY 2
`define FPE_ST_LVALID 3
`define FPE_ST_RD_ERR 4

// ************************************************
// Flash array limits
// ************************************************
`define FPE_FADR_W 16
`define FPE_FADR_TOP 16'h7fff
`define FPE_DUMMY_ONES 8'hff
`define FPE_ZERO_BYTE 8'h00
`define FPE_ZERO_WORD 32'h0000_0000

`endif

// >>> logic/fpe_pkg.sv
`include "fpe_defines.svh"
`default_nettype none
package fpe_pkg;
	// Classic Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [17:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} fpe_wb_req_t;

	// CPU access into the flash window
	typedef struct packed {
		logic stb;
		logic we;
		logic [`FPE_FADR_W-1:0] adr;
		logic [7:0] dat;
	} fpe_fl_req_t;

	// Controls toward the flash array macro
	typedef struct packed {
		logic prog;
		logic erase;
		logic pv_bias;
		logic ev_bias;
		logic [15:0] blk_sel;
		logic [`FPE_FADR_W-1:0] adr;
		logic [7:0] dat;
	} fpe_arr_ctl_t;
endpackage : fpe_pkg
`default_nettype wire

// >>> logic/fpe_reg8.sv
`include "fpe_defines.svh"
`default_nettype none
module fpe_reg8 #(
	parameter logic [7:0] RST_VAL = `FPE_RST_BYTE,
	parameter logic [7:0] WMASK = `FPE_ALL_WMASK
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [7:0] d_i,
	input wire logic [7:0] clr_i,
	output logic [7:0] q_o
);
	import fpe_pkg::*;

	logic [7:0] val_reg;
	logic [7:0] val_next;

	// Clear wins over a write: the clear is a safety drop
	always_comb begin
		val_next = val_reg;
		if (we_i) begin
			val_next = (d_i & WMASK) | (val_reg & ~WMASK);
		end
		val_next = val_next & ~clr_i;
	end

	// Storage, frozen while clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			val_reg <= RST_VAL;
		end else if (ce_i) begin
			val_reg <= val_next;
		end
	end

	assign q_o = val_reg;
endmodule // fpe_reg8
`default_nettype wire

// >>> logic/fpe_top.sv
// Register access over Wishbone was chosen for this implementation.
`include "fpe_defines.svh"
`default_nettype none
module fpe_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire fpe_pkg::fpe_wb_req_t wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Flash window access from the CPU
	input wire fpe_pkg::fpe_fl_req_t fl_i,
	output logic [7:0] fl_dat_o,
	output logic fl_ack_o,
	output logic fl_err_o,
	// Flash array macro
	input wire logic [7:0] arr_dat_i,
	output fpe_pkg::fpe_arr_ctl_t arr_o,
	// Mode and supply
	input wire logic rom_mode_i,
	input wire logic vpp_high_i,
	input wire logic standby_req_i,
	output logic standby_o,
	output logic user_prog_mode_o
);
	import fpe_pkg::*;

	// ************************************************
	// Wishbone decode
	// ************************************************
	logic [`FPE_IDX_W-1:0] idx;
	logic wb_go;
	logic wb_wr;
	logic hit_mode;
	logic hit_ebs1;
	logic hit_ebs2;
	logic hit_stat;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;

	assign idx = wb_i.adr[17:2];
	// One access per request; ack blocks a second take
	assign wb_go = wb_i.cyc & wb_i.stb & ~ack_reg;
	// Registers are one byte wide: only lane zero is honoured, so a
	// wide store cannot spill into a neighbouring register
	assign wb_wr = wb_go & wb_i.we & wb_i.sel[0];
	assign hit_mode = (idx == `FPE_IDX_MODE);
	assign hit_ebs1 = (idx == `FPE_IDX_EBS1);
	assign hit_ebs2 = (idx == `FPE_IDX_EBS2);
	assign hit_stat = (idx == `FPE_IDX_STAT);

	// ************************************************
	// Supply and user programming mode
	// ************************************************
	logic upm_reg;
	logic arr_busy;
	logic pulse_ok;
	logic fl_busy_reg;

	// Supply level is trusted as clean; a bouncing supply would toggle
	// the mode, so filtering is left to the board
	// Entry only with ROM mode and supply, not mid access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upm_reg <= 1'b0;
		end else if (ce_i) begin
			if (!(rom_mode_i && vpp_high_i)) begin
				upm_reg <= 1'b0;
			end else if (!fl_busy_reg && !fl_i.stb) begin
				upm_reg <= 1'b1;
			end
		end
	end

	// Pulses need both the supply and the mode
	assign pulse_ok = upm_reg & vpp_high_i;

	// Standby is held off while the supply is high
	assign standby_o = standby_req_i & ~vpp_high_i;
	// Peripherals see only this flag, nothing else changes
	assign user_prog_mode_o = upm_reg;

	// ************************************************
	// Mode control and block select registers
	// ************************************************
	logic [7:0] mode_q;
	logic [7:0] ebs1_q;
	logic [7:0] ebs2_q;
	logic [7:0] mode_clr;

	// A pulse bit left set by a runaway routine keeps stressing cells; hardware
	// drops it only when the supply or user mode goes, the time limit is left to software
	// Losing the supply drops both pulse bits at once
	always_comb begin
		mode_clr = `FPE_ZERO_BYTE;
		if (!pulse_ok) begin
			mode_clr[`FPE_BIT_PROG] = 1'b1;
			mode_clr[`FPE_BIT_ERASE] = 1'b1;
		end
	end

	// Mode control byte: pulse bits cleared by hardware, verify bits not
	fpe_reg8 #(
		.RST_VAL(`FPE_RST_BYTE),
		.WMASK(`FPE_MODE_WMASK)
	) u_mode (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.we_i(wb_wr & hit_mode),
		.d_i(wb_i.dat[7:0]),
		.clr_i(mode_clr),
		.q_o(mode_q)
	);

	// Block select bytes, one bit per block, never cleared by hardware
	fpe_reg8 #(
		.RST_VAL(`FPE_RST_BYTE),
		.WMASK(`FPE_ALL_WMASK)
	) u_ebs1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.we_i(wb_wr & hit_ebs1),
		.d_i(wb_i.dat[7:0]),
		.clr_i(`FPE_ZERO_BYTE),
		.q_o(ebs1_q)
	);

	fpe_reg8 #(
		.RST_VAL(`FPE_RST_BYTE),
		.WMASK(`FPE_ALL_WMASK)
	) u_ebs2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.we_i(wb_wr & hit_ebs2),
		.d_i(wb_i.dat[7:0]),
		.clr_i(`FPE_ZERO_BYTE),
		.q_o(ebs2_q)
	);

	// ************************************************
	// Mode decode
	// ************************************************
	logic prog_on;
	logic erase_on;
	logic pv_on;
	logic ev_on;

	// Verify biases are masked during a pulse so cells never see both
	// Program beats erase if software sets both
	assign prog_on = mode_q[`FPE_BIT_PROG] & pulse_ok;
	assign erase_on = mode_q[`FPE_BIT_ERASE] & pulse_ok & ~prog_on;
	assign pv_on = mode_q[`FPE_BIT_PV] & ~prog_on & ~erase_on;
	assign ev_on = mode_q[`FPE_BIT_EV] & ~prog_on & ~erase_on;
	assign arr_busy = prog_on | erase_on;

	// ************************************************
	// Address and data latches
	// ************************************************
	logic [`FPE_FADR_W-1:0] ladr_reg;
	logic [7:0] ldat_reg;
	logic lvalid_reg;
	logic evb_reg;
	logic fl_go;
	logic fl_wr;
	logic adr_ok;
	logic adr_bad_set;

	assign fl_go = fl_i.stb & ~fl_busy_reg;
	assign fl_wr = fl_go & fl_i.we;
	assign adr_ok = (fl_i.adr <= `FPE_FADR_TOP);
	assign adr_bad_set = fl_wr & ~adr_ok;

	// Hazard: moving the target mid-pulse would stress a second cell;
	// such writes are dropped without an error so software can retry
	// Latches freeze during a pulse so stress stays put
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ladr_reg <= '0;
			ldat_reg <= `FPE_ZERO_BYTE;
			lvalid_reg <= 1'b0;
		end else if (ce_i) begin
			if (fl_wr && adr_ok && !arr_busy) begin
				ladr_reg <= fl_i.adr;
				ldat_reg <= fl_i.dat;
				lvalid_reg <= 1'b1;
			end
		end
	end

	// Erase verify bias armed by an all-ones dummy write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evb_reg <= 1'b0;
		end else if (ce_i) begin
			if (!ev_on) begin
				evb_reg <= 1'b0;
			end else if (fl_wr && adr_ok && fl_i.dat == `FPE_DUMMY_ONES) begin
				evb_reg <= 1'b1;
			end
		end
	end

	// ************************************************
	// Array controls
	// ************************************************
	// Program stress only while the bit stands and a target is latched; erase needs its bit but no latched target
	always_comb begin
		arr_o.prog = prog_on & lvalid_reg;
		arr_o.erase = erase_on;
		arr_o.pv_bias = pv_on & lvalid_reg;
		arr_o.ev_bias = ev_on & evb_reg;
		arr_o.blk_sel = {ebs2_q, ebs1_q};
		arr_o.dat = ldat_reg;
		// Verify modes read from the latch, not the bus
		if (pv_on || ev_on || arr_busy) begin
			arr_o.adr = ladr_reg;
		end else begin
			arr_o.adr = fl_i.adr;
		end
	end

	// ************************************************
	// Flash window answers
	// ************************************************
	logic [7:0] fdat_reg;
	logic ferr_reg;
	logic rd_bad;

	// Reads during a pulse cannot return array data
	assign rd_bad = fl_go & ~fl_i.we & arr_busy;

	// Writes answer zero data: echoing the byte would look like a read
	// One cycle answer, data and error registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fl_busy_reg <= 1'b0;
			fdat_reg <= `FPE_ZERO_BYTE;
			ferr_reg <= 1'b0;
		end else if (ce_i) begin
			fl_busy_reg <= fl_go;
			if (fl_go) begin
				ferr_reg <= rd_bad | adr_bad_set;
				if (fl_i.we || rd_bad) begin
					fdat_reg <= `FPE_ZERO_BYTE;
				end else begin
					fdat_reg <= arr_dat_i;
				end
			end
		end
	end

	assign fl_ack_o = fl_busy_reg;
	assign fl_dat_o = fdat_reg;
	assign fl_err_o = ferr_reg;

	// ************************************************
	// Sticky status flags
	// ************************************************
	logic adr_err_reg;
	logic rd_err_reg;
	logic stat_clr;

	// Set wins so an event in the clearing cycle is never lost
	// Write one to clear; a new event wins the same cycle
	assign stat_clr = wb_wr & hit_stat;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adr_err_reg <= 1'b0;
			rd_err_reg <= 1'b0;
		end else if (ce_i) begin
			if (adr_bad_set) begin
				adr_err_reg <= 1'b1;
			end else if (stat_clr && wb_i.dat[`FPE_ST_ADR_ERR]) begin
				adr_err_reg <= 1'b0;
			end
			if (rd_bad) begin
				rd_err_reg <= 1'b1;
			end else if (stat_clr && wb_i.dat[`FPE_ST_RD_ERR]) begin
				rd_err_reg <= 1'b0;
			end
		end
	end

	// ************************************************
	// Register read mux and ack
	// ************************************************
	// Supply level shows in bit seven so software can poll it before
	// setting a pulse bit; writes to that bit are ignored
	// Unmapped reads answer zero, reserved bits read zero
	always_comb begin
		rdat_next = `FPE_ZERO_WORD;
		case (idx)
			`FPE_IDX_MODE: begin
				rdat_next[7:0] = mode_q;
				rdat_next[`FPE_BIT_VPP] = vpp_high_i;
			end
			`FPE_IDX_EBS1: begin
				rdat_next[7:0] = ebs1_q;
			end
			`FPE_IDX_EBS2: begin
				rdat_next[7:0] = ebs2_q;
			end
			`FPE_IDX_STAT: begin
				rdat_next[`FPE_ST_ADR_ERR] = adr_err_reg;
				rdat_next[`FPE_ST_UPM] = upm_reg;
				rdat_next[`FPE_ST_BUSY] = arr_busy;
				rdat_next[`FPE_ST_LVALID] = lvalid_reg;
				rdat_next[`FPE_ST_RD_ERR] = rd_err_reg;
			end
			`FPE_IDX_LADR: begin
				rdat_next[`FPE_FADR_W-1:0] = ladr_reg;
			end
			`FPE_IDX_LDAT: begin
				rdat_next[7:0] = ldat_reg;
			end
			default: begin
				rdat_next = `FPE_ZERO_WORD;
			end
		endcase
	end

	// Ack one cycle after the request, dropped next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= `FPE_ZERO_WORD;
		end else if (ce_i) begin
			ack_reg <= wb_go;
			if (wb_go && !wb_i.we) begin
				rdat_reg <= rdat_next;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
endmodule // fpe_top
`default_nettype wire

// >>> test/fpe_top_sva.sv
`default_nettype none
module fpe_top_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire fpe_pkg::fpe_wb_req_t wb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire fpe_pkg::fpe_fl_req_t fl_i,
	input wire logic [7:0] fl_dat_o,
	input wire logic fl_ack_o,
	input wire logic fl_err_o,
	input wire logic [7:0] arr_dat_i,
	input wire fpe_pkg::fpe_arr_ctl_t arr_o,
	input wire logic rom_mode_i,
	input wire logic vpp_high_i,
	input wire logic standby_req_i,
	input wire logic standby_o,
	input wire logic user_prog_mode_o
);
	import fpe_pkg::*;
	// ****************
	// Port checks
	// ****************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_standby_gate: assert property (standby_o == (standby_req_i && !vpp_high_i))
		else $error("standby with high supply");
	a_prog_gate: assert property (arr_o.prog |-> user_prog_mode_o && vpp_high_i)
		else $error("program stress outside user mode");
	a_erase_gate: assert property (arr_o.erase |-> user_prog_mode_o && vpp_high_i && !arr_o.prog)
		else $error("erase stress outside user mode");
	a_upm_leave: assert property (ce_i && !(rom_mode_i && vpp_high_i) |=> !user_prog_mode_o)
		else $error("user mode kept without supply");
	a_busy_read: assert property (ce_i && fl_i.stb && !fl_i.we && !fl_ack_o
		&& (arr_o.prog || arr_o.erase) |=> fl_ack_o && fl_err_o && fl_dat_o == 8'h00)
		else $error("array read served during pulse");
	a_top_refuse: assert property (ce_i && fl_i.stb && fl_i.we && !fl_ack_o
		&& fl_i.adr > 16'h7fff |=> fl_ack_o && fl_err_o)
		else $error("write above array not refused");
	a_wb_answer: assert property (ce_i && wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer late or long");
	a_pulse_latch: assert property (arr_o.prog && $past(arr_o.prog) |-> $stable(arr_o.adr) && $stable(arr_o.dat))
		else $error("latch moved during pulse");
	a_verify_excl: assert property (arr_o.pv_bias || arr_o.ev_bias |-> !arr_o.prog && !arr_o.erase)
		else $error("verify bias during pulse");
endmodule // fpe_top_sva
bind fpe_top fpe_top_sva fpe_top_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fl_i(fl_i), .fl_dat_o(fl_dat_o), .fl_ack_o(fl_ack_o),
	.fl_err_o(fl_err_o), .arr_dat_i(arr_dat_i), .arr_o(arr_o), .rom_mode_i(rom_mode_i),
	.vpp_high_i(vpp_high_i), .standby_req_i(standby_req_i), .standby_o(standby_o),
	.user_prog_mode_o(user_prog_mode_o));
`default_nettype wire

// >>> test/test_flash_program_erase_control.sv
`include "fpe_defines.svh"
`default_nettype none
module test_flash_program_erase_control;
	timeunit 1ns;
	timeprecision 1ps;
	import fpe_pkg::*;
	logic clk_i = 0, rst_i = 1, ce_i = 1, rom_mode_i = 0, vpp_high_i = 0, standby_req_i = 0;
	fpe_wb_req_t wb_i = '0;
	fpe_fl_req_t fl_i = '0;
	logic [7:0] arr_dat_i = 8'h00;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, fl_ack_o, fl_err_o, standby_o, user_prog_mode_o;
	logic [7:0] fl_dat_o, e1, e2, d;
	fpe_arr_ctl_t arr_o;
	logic [15:0] a;
	logic [32:0] wq[$];
	logic [8:0] fq[$];
	logic [32:0] ew;
	logic [8:0] ef;
	int n_errors = 0, checked = 0;
	integer seed = 32'h5a07_587e;
	// ****************
	// Clock and design
	// ****************
	always #5 clk_i = ~clk_i;
	fpe_top fpe_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .fl_i(fl_i), .fl_dat_o(fl_dat_o), .fl_ack_o(fl_ack_o), .fl_err_o(fl_err_o),
		.arr_dat_i(arr_dat_i), .arr_o(arr_o), .rom_mode_i(rom_mode_i), .vpp_high_i(vpp_high_i),
		.standby_req_i(standby_req_i), .standby_o(standby_o), .user_prog_mode_o(user_prog_mode_o));
	// ****************
	// Tasks
	// ****************
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Held until the edge that samples ack, released right after it
	task wb(input logic w, input logic [15:0] i, input logic [7:0] v, input logic [32:0] e);
		@(posedge clk_i);
		wb_i <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'h1, {24'h0000_00, v}};
		wq.push_back(e);
		@(posedge clk_i iff wb_ack_o === 1'b1);
		wb_i <= '0;
	endtask
	task wr(input logic [15:0] i, input logic [7:0] v);
		wb(1'b1, i, v, 33'h0_0000_0000);
	endtask
	task rd(input logic [15:0] i, input logic [7:0] v);
		wb(1'b0, i, 8'h00, {9'h100, 16'h0000, v});
	endtask
	task fl(input logic w, input logic [15:0] ad, input logic [7:0] v, input logic [8:0] e);
		@(posedge clk_i);
		fl_i <= '{1'b1, w, ad, v};
		fq.push_back(e);
		@(posedge clk_i iff fl_ack_o === 1'b1);
		fl_i <= '0;
	endtask
	task stop_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Oldest note is matched to each answer as it appears
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wq.size() > 0) begin
			ew = wq.pop_front();
			if (ew[32]) cmp(wb_dat_o, ew[31:0]);
		end
		if (fl_ack_o === 1'b1 && fq.size() > 0) begin
			ef = fq.pop_front();
			cmp({fl_err_o, fl_dat_o}, ef);
		end
	end
	// Whole run needs about two thousand cycles; this limit is armed once
	// at time zero and ends the run after 5000 cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		stop_test;
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		arr_dat_i <= 8'($random(seed));
		rd(`FPE_IDX_MODE, 8'h00);
		rd(`FPE_IDX_EBS1, 8'h00);
		rd(`FPE_IDX_EBS2, 8'h00);
		rd(16'hff81, 8'h00);
		e1 = 8'($random(seed));
		e2 = 8'($random(seed));
		wr(`FPE_IDX_EBS1, e1);
		wr(`FPE_IDX_EBS2, e2);
		rd(`FPE_IDX_EBS1, e1);
		rd(`FPE_IDX_EBS2, e2);
		wr(`FPE_IDX_MODE, 8'h04);
		rd(`FPE_IDX_MODE, 8'h04);
		wr(`FPE_IDX_MODE, 8'h00);
		// Supply up with no access in flight
		rom_mode_i <= 1;
		vpp_high_i <= 1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		cmp(user_prog_mode_o, 1);
		rd(`FPE_IDX_MODE, 8'h80);
		a = 16'($random(seed));
		a[15] = 1'b0;
		d = 8'($random(seed));
		fl(1'b1, a, d, 9'h000);
		rd(`FPE_IDX_STAT, 8'h0a);
		rd(`FPE_IDX_LDAT, d);
		fl(1'b1, a | 16'h8000, ~d, 9'h100);
		rd(`FPE_IDX_STAT, 8'h0b);
		wr(`FPE_IDX_STAT, 8'h01);
		rd(`FPE_IDX_STAT, 8'h0a);
		wr(`FPE_IDX_MODE, 8'h01);
		@(negedge clk_i);
		cmp(arr_o.prog, 1);
		fl(1'b0, a, 8'h00, 9'h100);
		fl(1'b1, a ^ 16'h0001, ~d, 9'h000);
		@(negedge clk_i);
		cmp({arr_o.adr, arr_o.dat}, {a, d});
		rd(`FPE_IDX_LDAT, d);
		repeat (1000) @(posedge clk_i);
		@(negedge clk_i);
		cmp(arr_o.prog, 1);
		wr(`FPE_IDX_MODE, 8'h00);
		@(negedge clk_i);
		cmp(arr_o.prog, 0);
		wr(`FPE_IDX_MODE, 8'h04);
		@(negedge clk_i);
		cmp({arr_o.pv_bias, arr_o.adr}, {1'b1, a});
		repeat (400) @(posedge clk_i);
		fl(1'b0, a, 8'h00, {1'b0, arr_dat_i});
		wr(`FPE_IDX_MODE, 8'h00);
		// Prewrite the target to zero before the erase
		fl(1'b1, a, `FPE_ZERO_BYTE, 9'h000);
		rd(`FPE_IDX_LDAT, `FPE_ZERO_BYTE);
		wr(`FPE_IDX_MODE, 8'h02);
		@(negedge clk_i);
		cmp({arr_o.erase, arr_o.blk_sel}, {1'b1, e2, e1});
		// Pulse scaled down: a full erase pulse would be a million cycles
		repeat (100) @(posedge clk_i);
		@(negedge clk_i);
		cmp(arr_o.erase, 1);
		wr(`FPE_IDX_MODE, 8'h00);
		@(negedge clk_i);
		cmp(arr_o.erase, 0);
		wr(`FPE_IDX_MODE, 8'h08);
		fl(1'b1, a, `FPE_DUMMY_ONES, 9'h000);
		@(negedge clk_i);
		cmp(arr_o.ev_bias, 1);
		fl(1'b0, a, 8'h00, {1'b0, arr_dat_i});
		wr(`FPE_IDX_MODE, 8'h00);
		// Standby held off while supply is high
		standby_req_i <= 1;
		@(negedge clk_i);
		cmp(standby_o, 0);
		@(posedge clk_i);
		vpp_high_i <= 0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		cmp({standby_o, user_prog_mode_o}, 2'b10);
		// Clock enable low freezes state: no entry while frozen
		@(posedge clk_i);
		ce_i <= 0;
		vpp_high_i <= 1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		cmp({standby_o, user_prog_mode_o}, 2'b00);
		@(posedge clk_i);
		ce_i <= 1;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		cmp(user_prog_mode_o, 1);
		@(posedge clk_i);
		vpp_high_i <= 0;
		repeat (2) @(posedge clk_i);
		wr(`FPE_IDX_MODE, 8'h01);
		@(negedge clk_i);
		cmp(arr_o.prog, 0);
		stop_test;
	end
endmodule // test_flash_program_erase_control
`default_nettype wire
